// ### tone_speaker_model.sv
// speaker side model: accumulates the high time seen on each audio pin
`timescale 1ns/1ps
`default_nettype none
module tone_speaker_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // audio pins from the device
   input wire logic [1:0] pins_i,
   // accumulated high cycles per pin, wraps freely
   output logic [15:0] high_cnt0_o,
   output logic [15:0] high_cnt1_o
);
   // each pin is heard on its own, so each keeps its own tally
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         high_cnt0_o <= 16'h0000;
         high_cnt1_o <= 16'h0000;
      end else begin
         high_cnt0_o <= high_cnt0_o + {15'h0000, pins_i[0]};
         high_cnt1_o <= high_cnt1_o + {15'h0000, pins_i[1]};
      end
   end
endmodule
`default_nettype wire

// ### tone_unit_control_regs.sv
// tone unit control registers, soft reset, volume mask and output pins
`timescale 1ns/1ps
`default_nettype none
module tone_unit_control_regs #(
   parameter int TICK_DIV = tone_unit_pkg::TICK_DIV_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // cpu register port
   input var tone_unit_pkg::reg_req_t bus_i,
   output logic [tone_unit_pkg::DATA_W-1:0] rdata_o,
   // tone data from the counter path
   input var tone_unit_pkg::tone_data_t tone_data_i,
   input wire logic tone_data_valid_i,
   output logic tone_data_take_o,
   // status and audio pins
   output logic [1:0] sequencer_state_field_o,
   output logic [1:0] audio_output_pins_o
);

   localparam int DW = tone_unit_pkg::DATA_W;

   logic soft_reset_bit_ff, nxt_soft_reset_bit;
   logic mode_select_bit_ff, nxt_mode_select_bit;
   logic sequencer_enable_bit_ff, nxt_sequencer_enable_bit;
   logic [1:0] volume_mask_field_ff, nxt_volume_mask_field;
   logic [DW-1:0] rdata_ff, nxt_rdata;
   logic [1:0] audio_ff, nxt_audio;
   logic [1:0] state_code_ff, nxt_state_code;
   logic wave;
   logic take;
   tone_unit_pkg::seq_state_t seq_state;
   logic wr_reset, wr_mode, wr_seq_en, wr_mask;

   assign wr_reset = bus_i.wr && bus_i.addr == tone_unit_pkg::SOFT_RESET_CONTROL_ADDR;
   assign wr_mode = bus_i.wr && bus_i.addr == tone_unit_pkg::TONE_MODE_SELECT_ADDR;
   assign wr_seq_en = bus_i.wr && bus_i.addr == tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR;
   assign wr_mask = bus_i.wr && bus_i.addr == tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR;

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   tone_wave_gen #(
      .TICK_DIV(TICK_DIV)
   ) u_gen (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sync_clr_i(soft_reset_bit_ff),
      .enable_i(sequencer_enable_bit_ff),
      .pwm_mode_i(mode_select_bit_ff),
      .data_i(tone_data_i),
      .data_valid_i(tone_data_valid_i),
      .data_take_o(take),
      .wave_o(wave),
      .state_o(seq_state)
   );

   // ------------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------------
   always_comb begin
      nxt_soft_reset_bit = soft_reset_bit_ff;
      nxt_mode_select_bit = mode_select_bit_ff;
      nxt_sequencer_enable_bit = sequencer_enable_bit_ff;
      nxt_volume_mask_field = volume_mask_field_ff;
      if (soft_reset_bit_ff) begin
         // hardware reinit clears the bit, any cpu write that cycle loses
         nxt_soft_reset_bit = 1'b0;
         nxt_mode_select_bit = tone_unit_pkg::MODE_RESET;
         nxt_sequencer_enable_bit = tone_unit_pkg::SEQ_EN_RESET;
         nxt_volume_mask_field = tone_unit_pkg::VOLUME_MASK_RESET;
      end else begin
         if (wr_reset) begin
            nxt_soft_reset_bit = bus_i.wdata[tone_unit_pkg::SOFT_RESET_BIT];
         end
         if (wr_mode) begin
            nxt_mode_select_bit = bus_i.wdata[tone_unit_pkg::MODE_SELECT_BIT];
         end
         if (wr_seq_en) begin
            nxt_sequencer_enable_bit = bus_i.wdata[tone_unit_pkg::SEQUENCER_ENABLE_BIT];
         end
         if (wr_mask) begin
            nxt_volume_mask_field =
               bus_i.wdata[tone_unit_pkg::VOLUME_MASK_LSB +: 2];
         end
      end
   end

   // ------------------------------------------------------------------
   // read data, status and pins
   // ------------------------------------------------------------------
   always_comb begin
      nxt_rdata = rdata_ff;
      if (bus_i.rd) begin
         nxt_rdata = tone_unit_pkg::READ_ZERO;
         if (bus_i.addr == tone_unit_pkg::SOFT_RESET_CONTROL_ADDR) begin
            nxt_rdata[tone_unit_pkg::SOFT_RESET_BIT] = soft_reset_bit_ff;
         end else if (bus_i.addr == tone_unit_pkg::TONE_MODE_SELECT_ADDR) begin
            nxt_rdata[tone_unit_pkg::MODE_SELECT_BIT] = mode_select_bit_ff;
         end else if (bus_i.addr == tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR) begin
            nxt_rdata[tone_unit_pkg::SEQUENCER_ENABLE_BIT] = sequencer_enable_bit_ff;
         end else if (bus_i.addr == tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR) begin
            nxt_rdata[tone_unit_pkg::VOLUME_MASK_LSB +: 2] = volume_mask_field_ff;
         end else if (bus_i.addr == tone_unit_pkg::SEQUENCER_STATUS_ADDR) begin
            nxt_rdata[1:0] = tone_unit_pkg::state_code(seq_state);
         end
      end
      nxt_state_code = tone_unit_pkg::state_code(seq_state);
      // both pins carry the same wave, each gated by its mask bit
      nxt_audio = {2{wave}} & volume_mask_field_ff;
      if (soft_reset_bit_ff) begin
         nxt_audio = 2'h0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         soft_reset_bit_ff <= 1'b0;
         mode_select_bit_ff <= tone_unit_pkg::MODE_RESET;
         sequencer_enable_bit_ff <= tone_unit_pkg::SEQ_EN_RESET;
         volume_mask_field_ff <= tone_unit_pkg::VOLUME_MASK_RESET;
         rdata_ff <= tone_unit_pkg::READ_ZERO;
         audio_ff <= 2'h0;
         state_code_ff <= tone_unit_pkg::ST_CODE_DISABLED;
      end else begin
         soft_reset_bit_ff <= nxt_soft_reset_bit;
         mode_select_bit_ff <= nxt_mode_select_bit;
         sequencer_enable_bit_ff <= nxt_sequencer_enable_bit;
         volume_mask_field_ff <= nxt_volume_mask_field;
         rdata_ff <= nxt_rdata;
         audio_ff <= nxt_audio;
         state_code_ff <= nxt_state_code;
      end
   end

   assign rdata_o = rdata_ff;
   assign audio_output_pins_o = audio_ff;
   assign sequencer_state_field_o = state_code_ff;
   assign tone_data_take_o = take;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_soft_reset_reinit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      soft_reset_bit_ff |=> (mode_select_bit_ff == tone_unit_pkg::MODE_RESET
         && !sequencer_enable_bit_ff && volume_mask_field_ff == 2'h0
         && seq_state == tone_unit_pkg::SEQ_DISABLED))
      else $error("soft reset did not reinitialise the unit");

   a_soft_reset_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (soft_reset_bit_ff && wr_reset && bus_i.wdata[0]) |=> !soft_reset_bit_ff)
      else $error("cpu write beat hardware clear of soft reset bit");

   a_upper_bits_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $past(bus_i.rd) |-> rdata_o[DW-1:2] == '0)
      else $error("unused register bits read non-zero");

   a_mode_write_stores: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_mode && !soft_reset_bit_ff) |=> mode_select_bit_ff == $past(bus_i.wdata[0]))
      else $error("mode select bit did not take the written value");

   a_enable_write_stores: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_seq_en && !soft_reset_bit_ff) |=> sequencer_enable_bit_ff == $past(bus_i.wdata[0]))
      else $error("sequencer enable bit did not take the written value");

   a_enable_starts_seq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (seq_state == tone_unit_pkg::SEQ_DISABLED && sequencer_enable_bit_ff
       && !soft_reset_bit_ff) |=> seq_state == tone_unit_pkg::SEQ_IDLE)
      else $error("enable did not start the sequencer");

   a_mask_silences: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (volume_mask_field_ff != 2'h3) |=>
         (audio_output_pins_o & ~$past(volume_mask_field_ff)) == 2'h0)
      else $error("masked audio pin still driven");

   a_status_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == tone_unit_pkg::SEQUENCER_STATUS_ADDR) |=>
         rdata_o[1:0] == tone_unit_pkg::state_code($past(seq_state)))
      else $error("status read did not report the sequencer state");

   a_pins_follow_wave: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (volume_mask_field_ff == 2'h3 && !soft_reset_bit_ff && wave) |=>
         audio_output_pins_o == 2'h3)
      else $error("unmasked pins did not follow the wave");

endmodule
`default_nettype wire

// ### tone_unit_control_regs_bench.sv
// self-checking bench for the tone unit control block
`timescale 1ns/1ps
`default_nettype none
module tone_unit_control_regs_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   tone_unit_pkg::reg_req_t bus = '0;
   tone_unit_pkg::tone_data_t tdata = '0;
   logic tvalid = 1'b0;
   logic [15:0] rdata;
   logic take;
   logic [1:0] st;
   logic [1:0] pins;
   logic [15:0] h0;
   logic [15:0] h1;
   int errors = 0;
   int total_checks = 0;

   always #10 clk = ~clk;

   tone_unit_control_regs u_tone_unit_control_regs (.clk_i(clk), .rst_n_i(rst_n), .bus_i(bus),
      .rdata_o(rdata), .tone_data_i(tdata), .tone_data_valid_i(tvalid),
      .tone_data_take_o(take), .sequencer_state_field_o(st), .audio_output_pins_o(pins));
   tone_speaker_model u_tone_speaker_model (.clk_i(clk), .rst_n_i(rst_n), .pins_i(pins),
      .high_cnt0_o(h0), .high_cnt1_o(h1));

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [27:0] a, input logic [15:0] d);
      @(posedge clk) bus <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk) bus <= '0;
   endtask

   task automatic rd_chk(input string what, input logic [27:0] a, input logic [15:0] exp);
      @(posedge clk) bus <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
      @(posedge clk) bus <= '0;
      #1 chk(what, exp, rdata);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wait_state(input logic [1:0] code);
      for (int i = 0; i < 3000 && st !== code; i++) tick(1);
   endtask

   // hands one tone block to the sequencer and drops valid once taken
   task automatic load(input logic [15:0] m, input logic [15:0] n, input logic [15:0] rep);
      @(posedge clk) tdata <= '{high_width: m, low_width: n, repeat_count: rep};
      tvalid <= 1'b1;
      for (int i = 0; i < 200 && take !== 1'b1; i++) tick(1);
      chk("data taken", 16'h0001, {15'h0000, take});
      @(posedge clk) tvalid <= 1'b0;
      #1;
      chk("take pulse", 16'h0000, {15'h0000, take});
   endtask

   function automatic logic [15:0] exp_high(input logic [15:0] m, input logic [15:0] rep,
                                            input logic on);
      exp_high = on ? m * ((rep == 16'h0000) ? 16'h0001 : rep) : 16'h0000;
   endfunction

   // one pwm block, enable cleared right after the load
   task automatic run_pwm(input logic [15:0] m, input logic [15:0] n, input logic [15:0] rep,
                          input logic [1:0] mask);
      logic [15:0] b0;
      logic [15:0] b1;
      wr(tone_unit_pkg::TONE_MODE_SELECT_ADDR, 16'h0001);
      wr(tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR, {14'h0000, mask});
      wr(tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR, 16'h0001);
      tick(3);
      chk("state idle", 16'h0003, {14'h0000, st});
      b0 = h0;
      b1 = h1;
      load(m, n, rep);
      chk("state cnt0", 16'h0002, {14'h0000, st});
      wr(tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR, 16'h0000);
      wait_state(2'b00);
      tick(3);
      chk("pin0 high time", exp_high(m, rep, mask[0]), h0 - b0);
      chk("pin1 high time", exp_high(m, rep, mask[1]), h1 - b1);
   endtask

   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      logic [15:0] b;
      int cnt;
      void'($urandom(32'hc028));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("reset reg", tone_unit_pkg::SOFT_RESET_CONTROL_ADDR, 16'h0000);
      rd_chk("mode reg", tone_unit_pkg::TONE_MODE_SELECT_ADDR, 16'h0001);
      rd_chk("enable reg", tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR, 16'h0000);
      rd_chk("mask reg", tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR, 16'h0000);
      rd_chk("status reg", tone_unit_pkg::SEQUENCER_STATUS_ADDR, 16'h0000);
      wr(tone_unit_pkg::TONE_MODE_SELECT_ADDR, 16'hfffe);
      rd_chk("mode upper", tone_unit_pkg::TONE_MODE_SELECT_ADDR, 16'h0000);
      wr(tone_unit_pkg::TONE_MODE_SELECT_ADDR, 16'hffff);
      rd_chk("mode set", tone_unit_pkg::TONE_MODE_SELECT_ADDR, 16'h0001);
      wr(tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR, 16'hffff);
      rd_chk("mask upper", tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR, 16'h0003);
      wr(28'hb00_0160, 16'hffff);
      rd_chk("unmapped", 28'hb00_0160, 16'h0000);
      wr(tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR, 16'hfffe);
      rd_chk("enable upper", tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR, 16'h0000);
      $display("test register map done");

      run_pwm(16'h0001, 16'h0001, 16'h0000, 2'b11);
      run_pwm(16'h0009, 16'h0003, 16'h0004, 2'b01);
      for (int i = 0; i < 6; i++) begin
         run_pwm(16'(2 + $urandom % 8), 16'(1 + $urandom % 8), 16'(1 + $urandom % 4),
                 2'($urandom % 4));
      end
      $display("test pwm drain done");

      wr(tone_unit_pkg::TONE_MODE_SELECT_ADDR, 16'h0000);
      wr(tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR, 16'h0003);
      wr(tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR, 16'h0001);
      load(16'h0004, 16'h0005, 16'h0001);
      chk("state cnt1", 16'h0001, {14'h0000, st});
      rd_chk("status buzz", tone_unit_pkg::SEQUENCER_STATUS_ADDR, 16'h0001);
      tick(15);
      b = h0;
      tick(20);
      chk("buzz high time", 16'h000a, h0 - b);
      wr(tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR, 16'h0000);
      tick(2);
      chk("muted pins", 16'h0000, {14'h0000, pins});
      b = h0 + h1;
      tick(20);
      chk("muted high time", 16'h0000, h0 + h1 - b);
      wr(tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR, 16'h0003);
      wr(tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR, 16'h0000);
      for (cnt = 0; cnt < 3000 && st !== 2'b00; cnt++) tick(1);
      chk("buzz drain bound", 16'h0001, {15'h0000, cnt <= 12});
      $display("test buzz done");

      wr(tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR, 16'h0001);
      load(16'h0004, 16'h0006, 16'h0001);
      tick(4);
      // held two edges: the second write lands while the bit is set and must lose
      @(posedge clk) bus <= '{addr: tone_unit_pkg::SOFT_RESET_CONTROL_ADDR, wr: 1'b1,
                              rd: 1'b0, wdata: 16'h0001};
      repeat (2) @(posedge clk);
      bus <= '0;
      tick(3);
      chk("pins after soft reset", 16'h0000, {14'h0000, pins});
      chk("state after soft reset", 16'h0000, {14'h0000, st});
      rd_chk("mode after soft", tone_unit_pkg::TONE_MODE_SELECT_ADDR, 16'h0001);
      rd_chk("enable after soft", tone_unit_pkg::SEQUENCER_ENABLE_CONTROL_ADDR, 16'h0000);
      rd_chk("mask after soft", tone_unit_pkg::OUTPUT_VOLUME_MASK_ADDR, 16'h0000);
      rd_chk("soft bit cleared", tone_unit_pkg::SOFT_RESET_CONTROL_ADDR, 16'h0000);
      $display("test soft reset done");
      close_out();
   end

   // hang guard at 20000 cycles, far beyond the few hundred cycles the tests need
   initial begin
      #400000;
      errors++;
      close_out();
   end
endmodule
`default_nettype wire

// ### tone_unit_pkg.sv
// constants and types shared by the tone unit control block
//--------------------------------------------------------------------
// What this block does
// - writing one to the soft reset bit reinitialises the unit like hardware reset
// - unused upper register bits read zero; software writes zero there
// - mode select bit 0: one selects pwm, zero buzz; resets to one
// - sequencer enable bit 0: one enables, zero requests disable; resets to zero
// - enabling a disabled sequencer starts output in the selected mode
// - disabling during pwm finishes the repeat count before stopping
// - disabling during buzz finishes the counter one period before stopping
// - two-bit volume mask gates each output pin; resets to silent
// - clearing a mask bit silences its pin at once, even mid waveform
// - state field reads 11 idle, 10 counter zero, 01 counter one, 00 disabled
// - pwm: counter zero times high, counter one low; buzz: counter one period
// - hardware update of a control bit wins over a same-cycle cpu write
//--------------------------------------------------------------------
package tone_unit_pkg;

   localparam int ADDR_W = 28;
   localparam int DATA_W = 16;
   localparam int CNT_W = 16;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] SOFT_RESET_CONTROL_ADDR = 28'hb00_0164;
   localparam logic [ADDR_W-1:0] TONE_MODE_SELECT_ADDR = 28'hb00_0166;
   localparam logic [ADDR_W-1:0] SEQUENCER_ENABLE_CONTROL_ADDR = 28'hb00_0168;
   localparam logic [ADDR_W-1:0] OUTPUT_VOLUME_MASK_ADDR = 28'hb00_016a;
   localparam logic [ADDR_W-1:0] SEQUENCER_STATUS_ADDR = 28'hb00_016c;

   localparam int SOFT_RESET_BIT = 0;
   localparam int MODE_SELECT_BIT = 0;
   localparam int SEQUENCER_ENABLE_BIT = 0;
   localparam int VOLUME_MASK_LSB = 0;

   localparam logic MODE_RESET = 1'h1;
   localparam logic MODE_PWM = 1'h1;
   localparam logic SEQ_EN_RESET = 1'h0;
   localparam logic [1:0] VOLUME_MASK_RESET = 2'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

   // sequencer state field codes
   localparam logic [1:0] ST_CODE_IDLE = 2'h3;
   localparam logic [1:0] ST_CODE_CNT0 = 2'h2;
   localparam logic [1:0] ST_CODE_CNT1 = 2'h1;
   localparam logic [1:0] ST_CODE_DISABLED = 2'h0;

   // sequencer time base: counts advance once per tick
   localparam int TICK_DIV_DEF = 1;

   typedef enum logic [1:0] {
      SEQ_DISABLED,
      SEQ_IDLE,
      SEQ_CNT0,
      SEQ_CNT1
   } seq_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic wr;
      logic rd;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [CNT_W-1:0] high_width;
      logic [CNT_W-1:0] low_width;
      logic [CNT_W-1:0] repeat_count;
   } tone_data_t;

   function automatic logic [1:0] state_code(input seq_state_t s);
      case (s)
         SEQ_IDLE: state_code = ST_CODE_IDLE;
         SEQ_CNT0: state_code = ST_CODE_CNT0;
         SEQ_CNT1: state_code = ST_CODE_CNT1;
         default: state_code = ST_CODE_DISABLED;
      endcase
   endfunction

endpackage

// ### tone_wave_gen.sv
// tone sequencer: counter timing, drain on disable, waveform
`timescale 1ns/1ps
`default_nettype none
module tone_wave_gen #(
   parameter int TICK_DIV = tone_unit_pkg::TICK_DIV_DEF
) (
   // clock and resets
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sync_clr_i,
   // control
   input wire logic enable_i,
   input wire logic pwm_mode_i,
   // tone data
   input var tone_unit_pkg::tone_data_t data_i,
   input wire logic data_valid_i,
   output logic data_take_o,
   // results
   output logic wave_o,
   output tone_unit_pkg::seq_state_t state_o
);

   localparam int CW = tone_unit_pkg::CNT_W;

   tone_unit_pkg::seq_state_t state_ff, nxt_state;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic [CW-1:0] rep_ff, nxt_rep;
   logic [CW-1:0] m_ff, nxt_m;
   logic [CW-1:0] n_ff, nxt_n;
   logic [CW-1:0] div_ff, nxt_div;
   logic wave_ff, nxt_wave;
   logic take_ff, nxt_take;
   logic tick;
   logic cnt_end;

   assign tick = (div_ff == CW'(TICK_DIV - 1));
   assign cnt_end = tick && (cnt_ff <= CW'(1));

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_rep = rep_ff;
      nxt_m = m_ff;
      nxt_n = n_ff;
      nxt_wave = wave_ff;
      nxt_take = 1'b0;
      nxt_div = tick ? '0 : div_ff + CW'(1);
      case (state_ff)
         tone_unit_pkg::SEQ_DISABLED: begin
            nxt_wave = 1'b0;
            if (enable_i) begin
               nxt_state = tone_unit_pkg::SEQ_IDLE;
            end
         end
         tone_unit_pkg::SEQ_IDLE: begin
            nxt_wave = 1'b0;
            if (!enable_i) begin
               nxt_state = tone_unit_pkg::SEQ_DISABLED;
            end else if (data_valid_i) begin
               nxt_take = 1'b1;
               nxt_m = data_i.high_width;
               nxt_n = data_i.low_width;
               nxt_rep = data_i.repeat_count;
               nxt_wave = 1'b1;
               nxt_div = '0;
               if (pwm_mode_i == tone_unit_pkg::MODE_PWM) begin
                  nxt_state = tone_unit_pkg::SEQ_CNT0;
                  nxt_cnt = data_i.high_width;
               end else begin
                  nxt_state = tone_unit_pkg::SEQ_CNT1;
                  nxt_cnt = data_i.low_width;
               end
            end
         end
         tone_unit_pkg::SEQ_CNT0: begin
            if (cnt_end) begin
               nxt_state = tone_unit_pkg::SEQ_CNT1;
               nxt_cnt = n_ff;
               nxt_wave = 1'b0;
            end else if (tick) begin
               nxt_cnt = cnt_ff - CW'(1);
            end
         end
         default: begin
            if (!cnt_end) begin
               if (tick) begin
                  nxt_cnt = cnt_ff - CW'(1);
               end
            end else if (pwm_mode_i == tone_unit_pkg::MODE_PWM) begin
               // the pair repeats whatever the enable bit says
               if (rep_ff > CW'(1)) begin
                  nxt_rep = rep_ff - CW'(1);
                  nxt_state = tone_unit_pkg::SEQ_CNT0;
                  nxt_cnt = m_ff;
                  nxt_wave = 1'b1;
               end else begin
                  nxt_wave = 1'b0;
                  nxt_state = enable_i ? tone_unit_pkg::SEQ_IDLE
                                       : tone_unit_pkg::SEQ_DISABLED;
               end
            end else if (!enable_i) begin
               nxt_state = tone_unit_pkg::SEQ_DISABLED;
               nxt_wave = 1'b0;
            end else begin
               nxt_cnt = n_ff;
               nxt_wave = !wave_ff;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= tone_unit_pkg::SEQ_DISABLED;
         cnt_ff <= '0;
         rep_ff <= '0;
         m_ff <= '0;
         n_ff <= '0;
         div_ff <= '0;
         wave_ff <= 1'b0;
         take_ff <= 1'b0;
      end else if (sync_clr_i) begin
         state_ff <= tone_unit_pkg::SEQ_DISABLED;
         cnt_ff <= '0;
         rep_ff <= '0;
         m_ff <= '0;
         n_ff <= '0;
         div_ff <= '0;
         wave_ff <= 1'b0;
         take_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         rep_ff <= nxt_rep;
         m_ff <= nxt_m;
         n_ff <= nxt_n;
         div_ff <= nxt_div;
         wave_ff <= nxt_wave;
         take_ff <= nxt_take;
      end
   end

   assign wave_o = wave_ff;
   assign state_o = state_ff;
   assign data_take_o = take_ff;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_pwm_drain_repeat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_ff == tone_unit_pkg::SEQ_CNT1 && pwm_mode_i && cnt_end && rep_ff > CW'(1)
       && !enable_i && !sync_clr_i) |=> (state_ff == tone_unit_pkg::SEQ_CNT0 && wave_ff))
      else $error("pwm pair not repeated during drain");

   a_buzz_drain_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_ff == tone_unit_pkg::SEQ_CNT1 && !pwm_mode_i && cnt_end && !enable_i)
      |=> (state_ff == tone_unit_pkg::SEQ_DISABLED && !wave_ff))
      else $error("buzz did not stop after its period");

   a_pwm_high_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_ff == tone_unit_pkg::SEQ_CNT0) |-> wave_ff)
      else $error("output low while counter zero times the high width");

endmodule
`default_nettype wire
